// ==== design/pnd_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the
// next-page / PCS / diagnostic register group.
// Assumes one 10 MHz clock shared by the PHY logic and its manager.
`ifndef PND_CFG_SVH
`define PND_CFG_SVH

// Register offsets on the 5-bit management address
`define PND_OFF_NP_TX_WORD 5'h07
`define PND_OFF_PCS_CONTROL 5'h10
`define PND_OFF_AN_STATE_A 5'h11
`define PND_OFF_AN_STATE_B 5'h12
`define PND_OFF_USER_WORD 5'h14
`define PND_OFF_RX_ERR_CNT 5'h15

// Next-page transmit word fields
`define PND_NP_PENDING_BIT 15
`define PND_NP_ACK_BIT 14
`define PND_NP_MSG_BIT 13
`define PND_NP_COMPLY_BIT 12
`define PND_NP_TOGGLE_BIT 11
`define PND_NP_CODE_MSB 10

// PCS control fields
`define PND_PCS_LOCK_BIT 15
`define PND_PCS_TEST_MSB 11
`define PND_PCS_TEST_LSB 4
`define PND_PCS_SCOPE_BIT 3
`define PND_PCS_SCAN_BIT 2
`define PND_PCS_FORCE_BIT 1
`define PND_PCS_FAST_BIT 0

// Receive error counter: mode bit and split-mode fields
`define PND_CNT_MODE_BIT 0
`define PND_CNT_FC_MSB 11
`define PND_CNT_FC_LSB 8
`define PND_CNT_DISC_MSB 15
`define PND_CNT_DISC_LSB 12

// Reset values
`define PND_RST_NP_WORD 16'h0000
`define PND_RST_PCS 16'h0000
`define PND_RST_USER 16'h0000
`define PND_RST_COUNT 16'h0000

// Link monitor interval, in ns, and the clock period
`define PND_CLK_PERIOD_NS 100
`define PND_LMON_NORM_NS 620000
`define PND_LMON_FAST_NS 10000
`define PND_LMON_FAST_CYC (`PND_LMON_FAST_NS / `PND_CLK_PERIOD_NS)

`endif

// ==== design/pnd_mgmt_if.sv ====
// Parallel management link between station controller and PHY registers.
// Assumes both ends run on the same clock; no tristate on this link.
`timescale 1ns/1ps
interface pnd_mgmt_if;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic reg_rvalid;

    modport dev (
        input reg_addr,
        input reg_wdata,
        input reg_wr,
        input reg_rd,
        output reg_rdata,
        output reg_rvalid
    );

    modport sta (
        output reg_addr,
        output reg_wdata,
        output reg_wr,
        output reg_rd,
        input reg_rdata,
        input reg_rvalid
    );
endinterface

// ==== design/pnd_phy_regs.sv ====
// PHY-side register group: next-page word, PCS control, autonegotiation
// state views, user output word and receive error counter.
// Assumes all status and event inputs come from logic on mclk_i.
`timescale 1ns/1ps
`include "pnd_cfg.svh"

// Functional notes
// - Next-page pending bit writable; 0 means last
// - Acknowledge bit read-only from link code word
// - Message-page flag writable: unformatted or formatted
// - Comply-acknowledge bit writable by software
// - First toggle is inverse of base bit 11
// - Eleven-bit writable page code payload field
// - PCS bit 15 shows live descrambler lock
// - PCS bits 14 to 12 read zero
// - Test bits stored, read back, no effect
// - Loopback scope: full PCS or collision-only
// - Forced loop: no idle, collision kept
// - Fast bit shortens link monitor interval
// - State A: zeros above thirteen arbitration flags
// - State B: sixteen link pulse indicators
// - User word held, driven out, readable
// - Counter mode bit write-only, resets 0
// - Sixteen-bit mode counts errors, read clears
// - Split mode counts errors in low byte
// - Split mode counts false carriers, bits 11:8
// - Split mode counts disconnects, bits 15:12
module pnd_phy_regs
    import pnd_pkg::*;
#(
    parameter int LMON_NORM_CYC = `PND_LMON_NORM_NS / `PND_CLK_PERIOD_NS
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    pnd_mgmt_if.dev mgmt,
    // Autonegotiation and PCS status from the PHY core, same clock
    input wire logic lcw_ack_i,
    input wire logic base_toggle_i,
    input wire logic np_start_i,
    input wire logic np_exchanged_i,
    input wire logic descr_locked_i,
    input wire logic loopback_req_i,
    input wire logic [12:0] an_arb_state_i,
    input wire logic [15:0] an_pulse_state_i,
    // Event pulses, one clock each
    input wire logic rx_err_i,
    input wire logic false_carrier_i,
    input wire logic link_disc_i,
    // Controls and views toward the PHY core
    output logic [15:0] np_tx_word_o,
    output logic pcs_loop_full_o,
    output logic pcs_loop_forced_o,
    output logic tx_idle_force_o,
    output logic col_disable_o,
    output logic [7:0] generic_test_field_o,
    output logic scan_mode_o,
    output logic [12:0] link_mon_cycles_o,
    output logic [15:0] user_word_bus_o
);

    pnd_dev_state_type st_q;
    pnd_dev_state_type st_d;

    // Write and read strobes decoded per register
    logic wr_np;
    logic wr_pcs;
    logic wr_user;
    logic wr_cnt;
    logic rd_cnt;
    // Assembled read views
    logic [15:0] np_word;
    logic [15:0] pcs_word;
    logic [15:0] cnt_base;
    logic [7:0] err_lo;
    logic [3:0] fc_cnt;
    logic [3:0] disc_cnt;
    // Incremented split-mode fields, kept apart from their start values
    logic [7:0] err_lo_n;
    logic [3:0] fc_n;
    logic [3:0] disc_n;

    // Address decode; unmapped offsets take no write and read zero
    assign wr_np = mgmt.reg_wr && (mgmt.reg_addr == `PND_OFF_NP_TX_WORD);
    assign wr_pcs = mgmt.reg_wr && (mgmt.reg_addr == `PND_OFF_PCS_CONTROL);
    assign wr_user = mgmt.reg_wr && (mgmt.reg_addr == `PND_OFF_USER_WORD);
    assign wr_cnt = mgmt.reg_wr && (mgmt.reg_addr == `PND_OFF_RX_ERR_CNT);
    assign rd_cnt = mgmt.reg_rd && (mgmt.reg_addr == `PND_OFF_RX_ERR_CNT);

    // Read views assembled from stored and live bits
    assign np_word = {st_q.np_pending, lcw_ack_i, st_q.msg_page, st_q.comply_ack,
                      st_q.toggle, st_q.page_code};
    assign pcs_word = {descr_locked_i, 3'b000, st_q.test_bits, st_q.loop_scope,
                       st_q.scan_mode, st_q.force_loop, st_q.fast_link_mon};

    // Counter start value: a read empties it, a mode change too
    assign cnt_base = (rd_cnt || wr_cnt) ? `PND_RST_COUNT : st_q.err_count;
    assign err_lo = cnt_base[7:0];
    assign fc_cnt = cnt_base[`PND_CNT_FC_MSB:`PND_CNT_FC_LSB];
    assign disc_cnt = cnt_base[`PND_CNT_DISC_MSB:`PND_CNT_DISC_LSB];

    // Next state of every register
    always_comb begin
        st_d = st_q;
        // Every read strobe is answered one clock later
        st_d.rvalid = mgmt.reg_rd;
        // Next-page word: only pending, message, comply and code are writable
        if (wr_np) begin
            st_d.np_pending = mgmt.reg_wdata[`PND_NP_PENDING_BIT];
            st_d.msg_page = mgmt.reg_wdata[`PND_NP_MSG_BIT];
            st_d.comply_ack = mgmt.reg_wdata[`PND_NP_COMPLY_BIT];
            st_d.page_code = mgmt.reg_wdata[`PND_NP_CODE_MSB:0];
        end
        // Toggle: seeded from the base page, then flips per exchange
        if (np_start_i) begin
            st_d.toggle = ~base_toggle_i;
        end else if (np_exchanged_i) begin
            st_d.toggle = ~st_q.toggle;
        end
        // PCS control; lock and the zero bits are not stored
        if (wr_pcs) begin
            st_d.test_bits = mgmt.reg_wdata[`PND_PCS_TEST_MSB:`PND_PCS_TEST_LSB];
            st_d.loop_scope = mgmt.reg_wdata[`PND_PCS_SCOPE_BIT];
            st_d.scan_mode = mgmt.reg_wdata[`PND_PCS_SCAN_BIT];
            st_d.force_loop = mgmt.reg_wdata[`PND_PCS_FORCE_BIT];
            st_d.fast_link_mon = mgmt.reg_wdata[`PND_PCS_FAST_BIT];
        end
        // User word: the whole word is writable
        if (wr_user) begin
            st_d.user_word = mgmt.reg_wdata;
        end
        // Mode bit is write-only; a mode change also empties the counter
        if (wr_cnt) begin
            st_d.split_mode = mgmt.reg_wdata[`PND_CNT_MODE_BIT];
        end
        // Counting: an event in the clearing cycle still counts as one
        err_lo_n = err_lo;
        fc_n = fc_cnt;
        disc_n = disc_cnt;
        if (!st_d.split_mode) begin
            // Sixteen-bit mode ignores false carrier and disconnect
            st_d.err_count = cnt_base;
            if (rx_err_i && (cnt_base != 16'hFFFF)) begin
                st_d.err_count = cnt_base + 16'h0001;
            end
        end else begin
            if (rx_err_i && (err_lo != 8'hFF)) begin
                err_lo_n = err_lo + 8'h01;
            end
            if (false_carrier_i && (fc_cnt != 4'hF)) begin
                fc_n = fc_cnt + 4'h1;
            end
            if (link_disc_i && (disc_cnt != 4'hF)) begin
                disc_n = disc_cnt + 4'h1;
            end
            st_d.err_count = {disc_n, fc_n, err_lo_n};
        end
        // Read data, captured with the strobe
        st_d.rdata = 16'h0000;
        if (mgmt.reg_rd) begin
            case (mgmt.reg_addr)
                `PND_OFF_NP_TX_WORD: st_d.rdata = np_word;
                `PND_OFF_PCS_CONTROL: st_d.rdata = pcs_word;
                `PND_OFF_AN_STATE_A: st_d.rdata = {3'b000, an_arb_state_i};
                `PND_OFF_AN_STATE_B: st_d.rdata = an_pulse_state_i;
                `PND_OFF_USER_WORD: st_d.rdata = st_q.user_word;
                `PND_OFF_RX_ERR_CNT: st_d.rdata = st_q.err_count;
                default: st_d.rdata = 16'h0000;
            endcase
        end
    end

    // Single state register
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            // Mode 0 after reset is the sixteen-bit counter
            st_q <= '0;
            st_q.user_word <= `PND_RST_USER;
            st_q.err_count <= `PND_RST_COUNT;
        end else begin
            st_q <= st_d;
        end
    end

    // Link answer: data and valid straight from flops
    assign mgmt.reg_rdata = st_q.rdata;
    assign mgmt.reg_rvalid = st_q.rvalid;
    // Word for the page transmitter; the acknowledge bit stays live
    assign np_tx_word_o = {st_q.np_pending, lcw_ack_i, st_q.msg_page, st_q.comply_ack,
                           st_q.toggle, st_q.page_code};

    // Loopback steering; forced loop keeps idle and collision untouched
    assign pcs_loop_full_o = loopback_req_i && st_q.loop_scope;
    assign tx_idle_force_o = loopback_req_i && st_q.loop_scope && !st_q.force_loop;
    assign col_disable_o = loopback_req_i && !st_q.force_loop;
    assign pcs_loop_forced_o = st_q.force_loop;

    // Test bits only leave the block; they steer nothing here
    assign generic_test_field_o = st_q.test_bits;
    assign scan_mode_o = st_q.scan_mode;

    // Link monitor interval for the PCS monitor counter
    assign link_mon_cycles_o = st_q.fast_link_mon ? 13'(`PND_LMON_FAST_CYC)
                                                  : 13'(LMON_NORM_CYC);

    // User word drives its output bus continuously
    assign user_word_bus_o = st_q.user_word;

endmodule // pnd_phy_regs

// ==== design/pnd_pkg.sv ====
// Types shared by both ends of the management register link.
// Assumes pnd_cfg.svh is compiled alongside.
package pnd_pkg;

    // Device-side state: every stored register field of the group plus the read port; state A and B views stay live
    typedef struct packed {
        logic np_pending;
        logic msg_page;
        logic comply_ack;
        logic [10:0] page_code;
        logic toggle;
        logic [7:0] test_bits;
        logic loop_scope;
        logic scan_mode;
        logic force_loop;
        logic fast_link_mon;
        logic [15:0] user_word;
        logic split_mode;
        logic [15:0] err_count;
        logic [15:0] rdata;
        logic rvalid;
    } pnd_dev_state_type;

    // Station-side sequencer states, one-hot
    typedef enum logic [2:0] {
        STA_IDLE = 3'b001,
        STA_ISSUE = 3'b010,
        STA_WAIT = 3'b100
    } pnd_sta_fsm_type;

    typedef struct packed {
        pnd_sta_fsm_type fsm;
        logic write;
        logic [4:0] addr;
        logic [15:0] wdata;
        logic rsp_valid;
        logic [15:0] rsp_data;
    } pnd_sta_state_type;

endpackage

// ==== design/pnd_sta_ctrl.sv ====
// Station management end: turns single read/write commands into
// register strobes on the management link and returns read data.
// Assumes the PHY answers a read exactly one clock after the strobe.
`timescale 1ns/1ps
`include "pnd_cfg.svh"

module pnd_sta_ctrl
    import pnd_pkg::*;
(
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    pnd_mgmt_if.sta mgmt,
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic [4:0] cmd_addr_i,
    input wire logic [15:0] cmd_wdata_i,
    output logic cmd_ready_o,
    output logic rsp_valid_o,
    output logic [15:0] rsp_data_o
);

    pnd_sta_state_type st_q;
    pnd_sta_state_type st_d;
    logic [15:0] wdata_fix;

    // Test bits of PCS control always go out as zero
    always_comb begin
        wdata_fix = cmd_wdata_i;
        if (cmd_addr_i == `PND_OFF_PCS_CONTROL) begin
            wdata_fix[`PND_PCS_TEST_MSB:`PND_PCS_TEST_LSB] = 8'h00;
        end
    end

    // One command in flight; next-page and mode writes pass unchanged
    always_comb begin
        st_d = st_q;
        st_d.rsp_valid = 1'b0;
        case (st_q.fsm)
            STA_IDLE: begin
                if (cmd_valid_i) begin
                    st_d.write = cmd_write_i;
                    st_d.addr = cmd_addr_i;
                    st_d.wdata = wdata_fix;
                    st_d.fsm = STA_ISSUE;
                end
            end
            STA_ISSUE: begin
                st_d.fsm = st_q.write ? STA_IDLE : STA_WAIT;
            end
            STA_WAIT: begin
                if (mgmt.reg_rvalid) begin
                    st_d.rsp_valid = 1'b1;
                    st_d.rsp_data = mgmt.reg_rdata;
                    st_d.fsm = STA_IDLE;
                end
            end
            default: begin
                st_d.fsm = STA_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st_q <= '{fsm: STA_IDLE, write: 1'b0, addr: 5'h00, wdata: 16'h0000,
                      rsp_valid: 1'b0, rsp_data: 16'h0000};
        end else begin
            st_q <= st_d;
        end
    end

    // Strobes come from the issue state, so they last one clock
    assign mgmt.reg_addr = st_q.addr;
    assign mgmt.reg_wdata = st_q.wdata;
    assign mgmt.reg_wr = (st_q.fsm == STA_ISSUE) && st_q.write;
    assign mgmt.reg_rd = (st_q.fsm == STA_ISSUE) && !st_q.write;
    assign cmd_ready_o = (st_q.fsm == STA_IDLE);
    assign rsp_valid_o = st_q.rsp_valid;
    assign rsp_data_o = st_q.rsp_data;

endmodule // pnd_sta_ctrl

// ==== sim/phy_next_page_diag_regs_tb.sv ====
// Testbench joining station end and PHY register end through the link.
// Assumes the design files and pnd_cfg.svh are compiled first.
`timescale 1ns/1ps
`include "pnd_cfg.svh"

module phy_next_page_diag_regs_tb;
    localparam int NORM = 20;
    logic mclk_i, sys_rst_i, lcw_ack_i, base_toggle_i, np_start_i, np_exchanged_i;
    logic descr_locked_i, loopback_req_i, rx_err_i, false_carrier_i, link_disc_i;
    logic [12:0] an_arb_state_i;
    logic [15:0] an_pulse_state_i, np_tx_word_o, user_word_bus_o, rsp_data_o, d;
    logic pcs_loop_full_o, pcs_loop_forced_o, tx_idle_force_o, col_disable_o, scan_mode_o;
    logic [7:0] generic_test_field_o;
    logic [12:0] link_mon_cycles_o;
    logic cmd_valid_i, cmd_write_i, cmd_ready_o, rsp_valid_o;
    logic [4:0] cmd_addr_i;
    logic [15:0] cmd_wdata_i;
    logic [4:0] addrs [6] = '{5'h07, 5'h10, 5'h11, 5'h12, 5'h14, 5'h1f};
    int errors = 0, cmp_count = 0, cycles = 0, seed = 32'h7dea7a0d;
    int m_np = 0, m_pcs = 0, m_user = 0, m_tog = 0;

    pnd_mgmt_if pnd_mgmt_if_inst ();
    pnd_phy_regs #(.LMON_NORM_CYC(NORM)) pnd_phy_regs_inst (.mclk_i, .sys_rst_i,
        .mgmt(pnd_mgmt_if_inst), .lcw_ack_i, .base_toggle_i, .np_start_i, .np_exchanged_i,
        .descr_locked_i, .loopback_req_i, .an_arb_state_i, .an_pulse_state_i, .rx_err_i,
        .false_carrier_i, .link_disc_i, .np_tx_word_o, .pcs_loop_full_o, .pcs_loop_forced_o,
        .tx_idle_force_o, .col_disable_o, .generic_test_field_o, .scan_mode_o,
        .link_mon_cycles_o, .user_word_bus_o);
    pnd_sta_ctrl pnd_sta_ctrl_inst (.mclk_i, .sys_rst_i, .mgmt(pnd_mgmt_if_inst),
        .cmd_valid_i, .cmd_write_i, .cmd_addr_i, .cmd_wdata_i, .cmd_ready_o,
        .rsp_valid_o, .rsp_data_o);
    pnd_link_props pnd_link_props_inst (.mclk_i, .sys_rst_i,
        .reg_addr(pnd_mgmt_if_inst.reg_addr), .reg_wdata(pnd_mgmt_if_inst.reg_wdata),
        .reg_wr(pnd_mgmt_if_inst.reg_wr), .reg_rd(pnd_mgmt_if_inst.reg_rd),
        .reg_rdata(pnd_mgmt_if_inst.reg_rdata), .reg_rvalid(pnd_mgmt_if_inst.reg_rvalid));

    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    task automatic test_done();
        $display("TB: %0d compares, %0d mismatches", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Hang guard: whole run needs under two thousand cycles
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            test_done();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One station command; valid drops once the taking edge has passed
    task automatic cmd(input logic wr, input logic [4:0] a, input logic [15:0] wd);
        int n;
        n = 0;
        cmd_valid_i = 1'b1;
        cmd_write_i = wr;
        cmd_addr_i = a;
        cmd_wdata_i = wd;
        @(posedge mclk_i);
        #1 cmd_valid_i = 1'b0;
        do begin
            @(posedge mclk_i);
            #1 n++;
        end while (!(cmd_ready_o === 1'b1 && (wr || rsp_valid_o === 1'b1)) && n < 10);
        if (n >= 10) begin
            errors++;
            $display("ERROR t=%0t ready=%h rsp=%h", $time, cmd_ready_o, rsp_valid_o);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] wd);
        cmd(1'b1, a, wd);
        if (a == `PND_OFF_NP_TX_WORD) m_np = wd;
        if (a == `PND_OFF_PCS_CONTROL) m_pcs = wd[3:0];
        if (a == `PND_OFF_USER_WORD) m_user = wd;
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        cmd(1'b0, a, 16'h0000);
        check(rsp_data_o, exp);
    endtask

    // Model view of a register; the station writes test bits as zero
    function automatic logic [15:0] exp_rd(input logic [4:0] a);
        case (a)
            `PND_OFF_NP_TX_WORD: exp_rd = 16'(m_np & 'hb7ff)
                | {1'b0, lcw_ack_i, 2'b00, m_tog[0], 11'h000};
            `PND_OFF_PCS_CONTROL: exp_rd = {descr_locked_i, 11'h000, 4'(m_pcs)};
            `PND_OFF_AN_STATE_A: exp_rd = {3'b000, an_arb_state_i};
            `PND_OFF_AN_STATE_B: exp_rd = an_pulse_state_i;
            `PND_OFF_USER_WORD: exp_rd = 16'(m_user);
            default: exp_rd = 16'h0000;
        endcase
    endfunction

    task automatic ev(input logic r, input logic f, input logic l);
        {rx_err_i, false_carrier_i, link_disc_i} = {r, f, l};
        @(posedge mclk_i);
        #1 {rx_err_i, false_carrier_i, link_disc_i} = 3'b000;
        @(posedge mclk_i);
        #1;
    endtask

    initial begin
        {sys_rst_i, lcw_ack_i, base_toggle_i, np_start_i, np_exchanged_i} = 5'b1_0000;
        {descr_locked_i, loopback_req_i, rx_err_i, false_carrier_i, link_disc_i} = 5'b0_0000;
        {cmd_valid_i, cmd_write_i, cmd_addr_i, cmd_wdata_i} = 23'h00_0000;
        {an_arb_state_i, an_pulse_state_i} = 29'h0000_0000;
        repeat (10) @(posedge mclk_i);
        #1 sys_rst_i = 1'b0;
        foreach (addrs[i]) rd(addrs[i], exp_rd(addrs[i]));
        // Random writes and readbacks with live status inputs moving
        for (int i = 0; i < 30; i++) begin
            {lcw_ack_i, descr_locked_i, loopback_req_i} = 3'($random(seed));
            an_arb_state_i = 13'($random(seed));
            an_pulse_state_i = 16'($random(seed));
            d = 16'($random(seed));
            wr(addrs[i % 6], d);
            rd(addrs[i%6], exp_rd(addrs[i%6]));
            check(np_tx_word_o, exp_rd(`PND_OFF_NP_TX_WORD));
            check(user_word_bus_o, 16'(m_user));
            check({8'h00, generic_test_field_o}, 16'h0000);
            check({15'h0000, scan_mode_o}, {15'h0000, m_pcs[2]}); // Scan bit reaches its pin
            check({12'h000, pcs_loop_full_o, tx_idle_force_o, col_disable_o, pcs_loop_forced_o},
                {12'h000, loopback_req_i & m_pcs[3], loopback_req_i & m_pcs[3] & ~m_pcs[1],
                loopback_req_i & ~m_pcs[1], m_pcs[1]});
            check({3'b000, link_mon_cycles_o},
                m_pcs[0] ? 16'(`PND_LMON_FAST_CYC) : 16'(NORM));
        end
        $display("test done: register readback");
        // First toggle from base bit 11, then alternating per exchange
        for (int b = 0; b < 2; b++) begin
            base_toggle_i = b[0];
            {np_start_i, np_exchanged_i} = 2'b11;
            @(posedge mclk_i);
            #1 {np_start_i, np_exchanged_i} = 2'b00;
            m_tog = ~b;
            for (int k = 0; k < 3; k++) begin
                check({15'h0000, np_tx_word_o[11]}, {15'h0000, m_tog[0]});
                @(posedge mclk_i);
                #1 np_exchanged_i = 1'b1;
                @(posedge mclk_i);
                #1 np_exchanged_i = 1'b0;
                m_tog = ~m_tog;
            end
            rd(`PND_OFF_NP_TX_WORD, exp_rd(`PND_OFF_NP_TX_WORD));
        end
        $display("test done: toggle");
        // Reset mode counts only receive errors across sixteen bits
        for (int i = 0; i < 40; i++) ev(1'b1, i < 9, i < 9);
        rd(`PND_OFF_RX_ERR_CNT, 16'd40);
        rd(`PND_OFF_RX_ERR_CNT, 16'h0000);
        wr(`PND_OFF_RX_ERR_CNT, 16'h0001);
        for (int i = 0; i < 260; i++) ev(1'b1, i < 5, i < 17);
        rd(`PND_OFF_RX_ERR_CNT, 16'hf5ff);
        rd(`PND_OFF_RX_ERR_CNT, 16'h0000);
        $display("test done: error counter");
        test_done();
    end
endmodule // phy_next_page_diag_regs_tb

// ==== sim/pnd_link_props.sv ====
// Checker for the management link between station and PHY registers.
// Assumes one clock, synchronous active-high reset, station-forced zero test bits.
`timescale 1ns/1ps
`include "pnd_cfg.svh"

module pnd_link_props (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid
);
    logic [15:0] np_q;
    logic [11:0] pcs_q;
    logic [15:0] user_q;
    logic mapped;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    // Shadows of writable bits, so each read can be judged against the last write
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            np_q <= 16'h0000;
            pcs_q <= 12'h000;
            user_q <= 16'h0000;
        end else if (reg_wr) begin
            if (reg_addr == `PND_OFF_NP_TX_WORD) np_q <= reg_wdata;
            if (reg_addr == `PND_OFF_PCS_CONTROL) pcs_q <= reg_wdata[11:0];
            if (reg_addr == `PND_OFF_USER_WORD) user_q <= reg_wdata;
        end
    end

    // Counter offset counts as mapped although its mode bit reads as count
    assign mapped = reg_addr inside {`PND_OFF_NP_TX_WORD, `PND_OFF_PCS_CONTROL,
        `PND_OFF_AN_STATE_A, `PND_OFF_AN_STATE_B, `PND_OFF_USER_WORD, `PND_OFF_RX_ERR_CNT};

    np_readback_a: assert property (reg_rd && reg_addr == `PND_OFF_NP_TX_WORD
        |=> (reg_rdata & 16'hb7ff) == (np_q & 16'hb7ff)) else $error("np word readback");
    pcs_unused_zero_a: assert property (reg_rd && reg_addr == `PND_OFF_PCS_CONTROL
        |=> reg_rdata[14:12] == 3'b000) else $error("pcs unused bits set");
    pcs_readback_a: assert property (reg_rd && reg_addr == `PND_OFF_PCS_CONTROL
        |=> reg_rdata[11:0] == pcs_q) else $error("pcs control readback");
    arb_top_zero_a: assert property (reg_rd && reg_addr == `PND_OFF_AN_STATE_A
        |=> reg_rdata[15:13] == 3'b000) else $error("state a top bits set");
    user_readback_a: assert property (reg_rd && reg_addr == `PND_OFF_USER_WORD
        |=> reg_rdata == user_q) else $error("user word readback");
    unmapped_zero_a: assert property (reg_rd && !mapped
        |=> reg_rvalid && reg_rdata == 16'h0000) else $error("unmapped read not zero");
    read_answer_a: assert property (reg_rd |=> reg_rvalid ##1 !reg_rvalid)
        else $error("read answer not a single pulse");
    idle_data_a: assert property (!reg_rvalid |-> reg_rdata == 16'h0000)
        else $error("read data outside answer");
    strobe_gap_a: assert property (reg_wr |=> !reg_wr && !reg_rd)
        else $error("strobe right after write");

    // Main scenarios reached
    cnt_read_c: cover property (reg_rd && reg_addr == `PND_OFF_RX_ERR_CNT);
    user_write_c: cover property (reg_wr && reg_addr == `PND_OFF_USER_WORD);
    unmapped_read_c: cover property (reg_rd && !mapped);
endmodule // pnd_link_props
